// ==== cbt_pkg.sv ====
package cbt_pkg;
   // Mode register addresses (6-bit MA field)
   localparam logic [5:0] MA_CA_REF = 6'h0c;
   localparam logic [5:0] MA_SP_CTRL = 6'h0d;
   localparam logic [5:0] MA_DQ_REF = 6'h0e;
   // Field positions
   localparam int REF_LEVEL_MSB = 5;
   localparam int REF_RANGE_BIT = 6;
   localparam int SP_TRAIN_BIT = 0;
   localparam int SP_HICUR_BIT = 3;
   localparam int SP_WRITE_SETPOINT_SELECT_BIT = 6;
   localparam int SP_OPERATING_SETPOINT_SET_BIT = 7;
   // Reset values
   localparam logic [7:0] CA_REF_RESET = 8'h4d;
   localparam logic [7:0] DQ_REF_RESET = 8'h4d;
   localparam logic [7:0] SP_CTRL_RESET = 8'h00;
   // Timing figures and derived counts
   localparam int CLK_PERIOD_PS = 5000;
   localparam int VREF_LONG_NS = 250;
   localparam int VREF_WEAK_US = 1000;
   localparam int VREF_LONG_CYC = (VREF_LONG_NS * 1000) / CLK_PERIOD_PS;
   localparam int VREF_WEAK_CYC = (VREF_WEAK_US * 1000 * 1000) / CLK_PERIOD_PS;
   localparam int MRD_CYC_DEF = 4;
   localparam int CAENT_CYC_DEF = 50;
   localparam int MRW_CYC_DEF = 4;
   localparam int CNT_W = 24;
   // Command bus: one mode register write
   typedef struct packed {
      logic valid;
      logic [5:0] addr;
      logic [7:0] data;
   } cbt_mrw_type;
   // Lower byte data pins seen in training
   typedef struct packed {
      logic mask_inv;
      logic [7:0] dq;
   } cbt_lo_in_type;
endpackage

// ==== cbt_sync.sv ====
`timescale 1ns/100ps
module cbt_sync
   import cbt_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Async in, synced out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   // Two-stage synchroniser; first stage read only by second
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// ==== cbt_train.sv ====
`timescale 1ns/100ps
// Operation
// [R1] DQ reference register: level bits 5..0, range bit 6, set by mode write.
// [R2] Controller spaces reference writes by 100 ns or 200 ns.
// [R3] Full-range reference change settles within 250 ns; busy flag shows it.
// [R4] High current mode off: every change settles up to 1 ms.
// [R5] Power-up runs from set-point zero.
// [R6] Controller selects write set-point one and programs it before training.
// [R7] Controller enters training by mode write setting control bit 0.
// [R8] After mode delay, clock-enable low switches to alternate set-point.
// [R9] Clock-enable high reverts to the set-point active before training.
// [R10] Trained CA reference is not kept; controller rewrites it.
// [R11] Lower strobe toggles capture data pins 6..0.
// [R12] Pins 5..0 give CA level, pin 6 gives CA range.
// [R13] Captured pin n maps to CA reference bit n.
// [R14] Pin 7 and lower mask pin are ignored in training.
// [R15] Pins 13..8 drive back latched CA values.
// [R16] Upper strobes, upper mask, pins 15..14 stay undriven.
// [R17] Strobe updates accepted only after training entry delay.
// [R18] Controller waits long settle time after each CA setting.
// [R19] Echo follows latched CA with no read command.
// [R20] Exit: clock-enable high, wait, mode write clearing bit 0, wait.
// [R21] Entry from idle or self refresh alike, clock-enable high first.
// [R22] Controller trains terminating rank first.
// [R23] CA bit k drives data pin 8+k.
// [R24] Controller gives two strobe pulses per code.
// [R25] Delays are configurable cycle counts.
module cbt_train
   import cbt_pkg::*;
#(
   parameter int MRD_CYC = MRD_CYC_DEF, // [R25]
   parameter int CAENT_CYC = CAENT_CYC_DEF,
   parameter int LONG_CYC = VREF_LONG_CYC,
   parameter int WEAK_CYC = VREF_WEAK_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Command side from controller
   input wire cbt_mrw_type mrw,
   input wire logic cke,
   input wire logic cs,
   input wire logic [5:0] ca,
   // Lower byte pins, inputs in training
   input wire logic dqs_lo_t,
   input wire logic dqs_lo_c,
   input wire cbt_lo_in_type lo_in,
   // Upper byte pins
   output logic [7:0] dq_hi_out,
   output logic [7:0] dq_hi_oe,
   output logic dqs_hi_out,
   output logic dqs_hi_oe,
   output logic mask_hi_out,
   output logic mask_hi_oe,
   // State seen by the rest of the die
   output logic [7:0] dq_reference_setting,
   output logic [7:0] ca_reference_setting,
   output logic [7:0] setpoint_control_reg,
   output logic operating_setpoint_set,
   output logic command_bus_training_mode,
   output logic ref_settling
);
   // Sequencer states; ENTRY covers the strobe lockout after clock-enable falls
   typedef enum logic [1:0] {
      ST_NORMAL,
      ST_ARMED,
      ST_ENTRY,
      ST_TRAIN
   } cbt_state_type;

   // Sequencer state
   cbt_state_type state_q;
   cbt_state_type state_d;
   // Mode registers and the temporary trained CA value
   logic [7:0] dq_ref_q;
   logic [7:0] ca_ref_q;
   logic [7:0] sp_q;
   logic [7:0] ca_train_q;
   // Set-point in use right now
   logic fsp_live_q;
   // Down counters for entry delays and reference settling
   logic [CNT_W-1:0] dly_q;
   logic [CNT_W-1:0] settle_q;
   // CA value caught on the last chip select rise in training
   logic [5:0] ca_latch_q;
   // One-cycle history for edge detection
   logic cke_q;
   logic cs_q;
   logic dqs_q;
   logic dqs_prev_q;
   // Synchronised pin levels
   logic [5:0] ca_s;
   logic [7:0] dq_s;
   logic cke_n_s;
   logic cke_s;
   logic cs_s;
   logic dqs_s;
   logic mask_s;
   // Strobe pair folded to one level before crossing
   logic strobe_pins;

   // Control pins; clock-enable crosses inverted so the synchroniser's
   // reset level matches the idle-high pin and no false edge follows reset
   assign strobe_pins = dqs_lo_t & ~dqs_lo_c;
   cbt_sync #(.W(3)) u_sync_ctrl (
      .clk(clk),
      .rst(rst),
      .d({~cke, cs, strobe_pins}),
      .q({cke_n_s, cs_s, dqs_s})
   );
   assign cke_s = ~cke_n_s;

   // Data-side pins; bit 7 and the mask pin cross but are never used
   // Limitation: a pin changing at a strobe edge may land one cycle apart
   cbt_sync #(.W(15)) u_sync_data (
      .clk(clk),
      .rst(rst),
      .d({ca, lo_in.dq, lo_in.mask_inv}),
      .q({ca_s, dq_s, mask_s})
   );

   // Decode of mode writes and pin events
   // Mode writes arrive on our own clock, so they need no synchroniser
   wire mrw_ca = mrw.valid && (mrw.addr == MA_CA_REF);
   wire mrw_dq = mrw.valid && (mrw.addr == MA_DQ_REF);
   wire mrw_sp = mrw.valid && (mrw.addr == MA_SP_CTRL);
   wire train_en = sp_q[SP_TRAIN_BIT];

   // Pin events: clock-enable and chip select in the cycle the synchronised level changes, strobe one cycle after
   wire cke_fall = cke_q & ~cke_s;
   wire cke_rise = ~cke_q & cke_s;
   wire dqs_edge = dqs_q ^ dqs_prev_q; // Both edges capture; last one wins
   wire cs_rise = cs_s & ~cs_q;

   // Training phase qualifiers
   wire in_train = (state_q == ST_ENTRY) || (state_q == ST_TRAIN);
   wire accept_ca = (state_q == ST_TRAIN) && dqs_edge; // [R17]

   // Reference settling; any reference change restarts the window
   wire hicur = sp_q[SP_HICUR_BIT];
   wire ref_write = mrw_ca || mrw_dq || accept_ca;
   // Settle window: 250 ns with high current mode, 1 ms without
   wire [CNT_W-1:0] settle_len = hicur ? CNT_W'(LONG_CYC) : CNT_W'(WEAK_CYC); // [R3] [R4]
   wire dly_done = (dly_q == '0);

   // Training sequencer
   // Leaving needs only clock-enable high; the control bit is cleared later
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_NORMAL: begin
            if (train_en) state_d = ST_ARMED; // [R7] [R21]
         end
         ST_ARMED: begin
            if (!train_en) state_d = ST_NORMAL;
            else if (dly_done && cke_fall) state_d = ST_ENTRY; // [R8]
         end
         ST_ENTRY: begin
            if (cke_rise) state_d = ST_NORMAL;
            else if (dly_done) state_d = ST_TRAIN;
         end
         ST_TRAIN: begin
            if (cke_rise) state_d = ST_NORMAL; // [R20]
         end
      endcase
   end

   // Delay counter for mode and entry delays
   // Reloaded on arming and on entry; idles at zero otherwise
   always_ff @(posedge clk) begin
      if (rst) begin
         dly_q <= '0;
      end else if (state_q == ST_NORMAL && train_en) begin
         dly_q <= CNT_W'(MRD_CYC);
      end else if (state_q == ST_ARMED && state_d == ST_ENTRY) begin
         dly_q <= CNT_W'(CAENT_CYC);
      end else if (!dly_done) begin
         dly_q <= dly_q - CNT_W'(1);
      end
   end

   // Pin history and state
   // History resets to idle pin levels: clock-enable high, strobe low
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_NORMAL;
         cke_q <= 1'b1;
         cs_q <= 1'b0;
         dqs_q <= 1'b0;
         dqs_prev_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cke_q <= cke_s;
         cs_q <= cs_s;
         dqs_q <= dqs_s;
         dqs_prev_q <= dqs_q;
      end
   end

   // Mode registers; each write goes only to its addressed register, in training or not
   // Each address owns one register, so two writes never collide
   always_ff @(posedge clk) begin
      if (rst) begin
         dq_ref_q <= DQ_REF_RESET;
         ca_ref_q <= CA_REF_RESET;
         sp_q <= SP_CTRL_RESET; // [R5]
      end else begin
         if (mrw_dq) begin
            dq_ref_q <= mrw.data; // [R1]
         end
         if (mrw_ca) begin
            ca_ref_q <= mrw.data;
         end
         if (mrw_sp) begin
            sp_q <= mrw.data;
         end
      end
   end

   // Temporary CA reference from strobes; dropped on exit
   // Seeded from the register on arming so training starts from a known value
   always_ff @(posedge clk) begin
      if (rst) begin
         ca_train_q <= CA_REF_RESET;
      end else if (state_q == ST_ARMED) begin
         ca_train_q <= ca_ref_q;
      end else if (accept_ca) begin
         ca_train_q <= {1'b0, dq_s[REF_RANGE_BIT:0]}; // [R11] [R12] [R13] [R14]
      end
   end

   // Live set-point flips on entry, back on exit
   // Outside training it simply follows the control register
   always_ff @(posedge clk) begin
      if (rst) begin
         fsp_live_q <= 1'b0;
      end else if (state_q == ST_ARMED && state_d == ST_ENTRY) begin
         fsp_live_q <= ~sp_q[SP_OPERATING_SETPOINT_SET_BIT]; // [R8]
      end else if (in_train && state_d == ST_NORMAL) begin
         fsp_live_q <= sp_q[SP_OPERATING_SETPOINT_SET_BIT]; // [R9] [R10]
      end else if (!in_train) begin
         fsp_live_q <= sp_q[SP_OPERATING_SETPOINT_SET_BIT];
      end
   end

   // Reference settle timer restarts on each change
   // One timer serves both references: the latest change sets the wait
   always_ff @(posedge clk) begin
      if (rst) begin
         settle_q <= '0;
      end else if (ref_write) begin
         settle_q <= settle_len;
      end else if (settle_q != '0) begin
         settle_q <= settle_q - CNT_W'(1);
      end
   end

   // CA latched on chip select, echoed without a read
   // The echo value holds until the next chip select rise in training, even after exit
   always_ff @(posedge clk) begin
      if (rst) begin
         ca_latch_q <= '0;
      end else if (in_train && cs_rise) begin
         ca_latch_q <= ca_s; // [R15]
      end
   end

   // Upper byte, one slice per pin: 13..8 echo CA, 15..14 left floating
   // Floating the spare pins saves drivers and is allowed in training
   for (genvar i = 0; i < 8; i++) begin : g_hi
      if (i < 6) begin : g_echo
         assign dq_hi_out[i] = ca_latch_q[i]; // [R23] [R19]
         assign dq_hi_oe[i] = in_train; // [R15]
      end else begin : g_float
         assign dq_hi_out[i] = 1'b0;
         assign dq_hi_oe[i] = 1'b0; // [R16]
      end
   end

   // Upper strobe and mask never driven
   assign dqs_hi_out = 1'b0;
   assign dqs_hi_oe = 1'b0; // [R16]
   assign mask_hi_out = 1'b0;
   assign mask_hi_oe = 1'b0;

   // Visible register state
   // The CA reference shows the temporary value while training runs
   assign dq_reference_setting = dq_ref_q;
   assign ca_reference_setting = in_train ? ca_train_q : ca_ref_q; // [R10]
   assign setpoint_control_reg = sp_q;
   assign operating_setpoint_set = fsp_live_q;
   assign command_bus_training_mode = in_train;
   assign ref_settling = (settle_q != '0); // [R3] [R4]
endmodule

// ==== cbt_ctrl_model.sv ====
`timescale 1ns/100ps
module cbt_ctrl_model
   import cbt_pkg::*;
(
   // Strobe pair and lower byte pins
   output logic dqs_t,
   output logic dqs_c,
   output cbt_lo_in_type lo_in
);
   // Strobe idles low between codes
   initial begin
      dqs_t = 1'b0;
      dqs_c = 1'b1;
      lo_in = '0;
   end
   // Two full pulses per code, since the first edge may be lost
   task automatic send(input logic [8:0] v);
      lo_in = v;
      repeat (4) begin
         #40;
         dqs_t = ~dqs_t;
         dqs_c = ~dqs_c;
      end
      #40;
      lo_in = ~v; // Released pins must not keep the old code
   endtask
endmodule

// ==== cbt_train_monitor.sv ====
`timescale 1ns/100ps
module cbt_train_monitor
   import cbt_pkg::*;
#(
   parameter int LONG_CYC = 50,
   parameter int WEAK_CYC = 100
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Watched ports
   input wire cbt_mrw_type mrw,
   input wire logic [7:0] dq_hi_oe,
   input wire logic dqs_hi_oe,
   input wire logic mask_hi_oe,
   input wire logic [7:0] dq_reference_setting,
   input wire logic [7:0] setpoint_control_reg,
   input wire logic operating_setpoint_set,
   input wire logic command_bus_training_mode,
   input wire logic ref_settling
);
   localparam int LONG_MAX = LONG_CYC + 2;
   localparam int WEAK_MID = WEAK_CYC - 20;
   // Write decode and set-point bits
   wire dq_wr = mrw.valid && mrw.addr == MA_DQ_REF;
   wire tm = command_bus_training_mode;
   wire op_bit = setpoint_control_reg[SP_OPERATING_SETPOINT_SET_BIT];
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Reference writes with high current on or off
   sequence s_fast_wr;
      dq_wr && setpoint_control_reg[SP_HICUR_BIT];
   endsequence
   sequence s_slow_wr;
      dq_wr && !setpoint_control_reg[SP_HICUR_BIT];
   endsequence
   AST_RESET_STATE: assert property (disable iff (1'b0)
      rst |=> dq_reference_setting == DQ_REF_RESET && setpoint_control_reg == SP_CTRL_RESET && !op_bit)
      else $error("state after reset wrong");
   AST_DQ_WRITE: assert property (dq_wr |=> dq_reference_setting == $past(mrw.data))
      else $error("reference write not taken");
   AST_FAST_SETTLE: assert property (s_fast_wr |-> ##[1:2] ref_settling ##[1:LONG_MAX] !ref_settling)
      else $error("fast settle too long");
   AST_WEAK_SETTLE: assert property (s_slow_wr |-> ##WEAK_MID ref_settling)
      else $error("weak settle ended early");
   AST_ALT_SET: assert property (tm && $past(tm) |-> operating_setpoint_set != op_bit)
      else $error("training not on alternate set");
   AST_REVERT: assert property (
      !tm && !$past(tm) && !$past(tm, 2) && $past(setpoint_control_reg, 2) == setpoint_control_reg
      |-> operating_setpoint_set == op_bit)
      else $error("set-point not restored");
   AST_ECHO_OE: assert property (dq_hi_oe == (tm ? 8'h3f : 8'h00))
      else $error("echo pin enables wrong");
   AST_HI_IDLE: assert property (!dqs_hi_oe && !mask_hi_oe && dq_hi_oe[7:6] == 2'h0)
      else $error("upper byte pins driven");
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
   import cbt_pkg::*;
   // Controller side pins and die outputs
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cke = 1'b1;
   logic cs = 1'b0;
   logic [5:0] ca = 6'h00;
   cbt_mrw_type mrw = '0;
   logic dqs_t;
   logic dqs_c;
   cbt_lo_in_type lo_in;
   logic [7:0] dq_hi_out;
   logic [7:0] dq_hi_oe;
   logic [7:0] dq_ref;
   logic [7:0] ca_ref;
   logic [7:0] sp;
   logic oss;
   logic tm;
   logic settling;
   int num_errors = 0;
   int samples_checked = 0;
   always #2.5 clk = ~clk;
   cbt_ctrl_model ctl (.dqs_t(dqs_t), .dqs_c(dqs_c), .lo_in(lo_in));
   // Weak settle shortened to keep the run brief
   cbt_train #(.WEAK_CYC(100)) dut (
      .clk(clk), .rst(rst), .mrw(mrw), .cke(cke), .cs(cs), .ca(ca), .dqs_lo_t(dqs_t), .dqs_lo_c(dqs_c),
      .lo_in(lo_in), .dq_hi_out(dq_hi_out), .dq_hi_oe(dq_hi_oe), .dqs_hi_out(), .dqs_hi_oe(), .mask_hi_out(),
      .mask_hi_oe(), .dq_reference_setting(dq_ref), .ca_reference_setting(ca_ref), .setpoint_control_reg(sp),
      .operating_setpoint_set(oss), .command_bus_training_mode(tm), .ref_settling(settling));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One-cycle mode write pulse
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge clk);
      mrw = '{1'b1, a, d};
      @(negedge clk);
      mrw = '0;
   endtask
   // Bounded wait; a hang ends the run
   task automatic wait_flag(ref logic f, input logic v, input int lim);
      int n;
      n = 0;
      while (f !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (f !== v) begin
         num_errors++;
         $display("CHECK FAILED wait expected %b seen %b", v, f);
         report_and_stop();
      end
   endtask
   task automatic test_reset;
      chk("dq_ref", DQ_REF_RESET, dq_ref);
      chk("sp", SP_CTRL_RESET, sp);
      chk("oss", 8'h00, {7'h0, oss});
      $display("test_reset done");
   endtask
   task automatic test_dq_ref;
      wr(MA_SP_CTRL, 8'h08);
      wr(MA_DQ_REF, 8'h7f);
      chk("dq_ref", 8'h7f, dq_ref);
      repeat (3) @(negedge clk);
      wait_flag(settling, 1'b0, 60);
      wr(MA_SP_CTRL, 8'h00);
      wr(MA_DQ_REF, 8'h00);
      repeat (60) @(negedge clk);
      chk("settling", 8'h01, {7'h0, settling});
      wait_flag(settling, 1'b0, 60);
      $display("test_dq_ref done");
   endtask
   task automatic test_train;
      wr(MA_SP_CTRL, 8'h48);
      wr(MA_CA_REF, 8'h1a);
      wr(MA_SP_CTRL, 8'h49);
      repeat (6) @(negedge clk);
      cke = 1'b0;
      wait_flag(tm, 1'b1, 10);
      chk("oss", 8'h01, {7'h0, oss});
      ctl.send(9'h12a);
      chk("early", 8'h1a, ca_ref);
      repeat (30) @(negedge clk);
      ctl.send(9'h1d5);
      repeat (8) @(negedge clk);
      chk("ca_ref", 8'h55, {1'b0, ca_ref[6:0]});
      wait_flag(settling, 1'b0, 60);
      ca = 6'h2d;
      repeat (2) @(negedge clk);
      cs = 1'b1;
      repeat (4) @(negedge clk);
      cs = 1'b0;
      ca = 6'h12;
      repeat (4) @(negedge clk);
      chk("echo", 8'h2d, {2'h0, dq_hi_out[5:0]});
      cke = 1'b1;
      wait_flag(tm, 1'b0, 10);
      chk("oss", 8'h00, {7'h0, oss});
      chk("ca_ref", 8'h1a, ca_ref);
      repeat (50) @(negedge clk);
      wr(MA_SP_CTRL, 8'h48);
      chk("sp", 8'h48, sp);
      $display("test_train done");
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      test_reset();
      test_dq_ref();
      test_train();
      report_and_stop();
   end
endmodule
bind cbt_train cbt_train_monitor #(.LONG_CYC(LONG_CYC), .WEAK_CYC(WEAK_CYC)) mon (
   .clk(clk), .rst(rst), .mrw(mrw), .dq_hi_oe(dq_hi_oe), .dqs_hi_oe(dqs_hi_oe), .mask_hi_oe(mask_hi_oe),
   .dq_reference_setting(dq_reference_setting), .setpoint_control_reg(setpoint_control_reg),
   .operating_setpoint_set(operating_setpoint_set), .command_bus_training_mode(command_bus_training_mode),
   .ref_settling(ref_settling));
